/* File: fpt_pkg.sv */
package fpt_pkg;
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] OFS_OP_ADDR = 8'h00;
	localparam logic [7:0] OFS_OP_DATA = 8'h04;
	localparam logic [7:0] OFS_OP_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_INT_MASK = 8'h10;
	localparam logic [7:0] OFS_READ_EN = 8'h30;
	localparam logic [7:0] OFS_PROG_EN = 8'h34;
	localparam logic [7:0] OFS_USEC_RELOAD = 8'h40;
	// operation control bits
	localparam int CTRL_WRITE_BIT = 0;
	localparam int CTRL_ERASE_BIT = 1;
	localparam int CTRL_COMMIT_BIT = 3;
	// status and mask bits
	localparam int STAT_ACCESS_FAULT_BIT = 0;
	localparam int STAT_READ_FAULT_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	// protection geometry
	localparam int BLOCKS = 16;
	localparam int BLOCK_SHIFT = 11;
	localparam int PAGE_SHIFT = 10;
	localparam int FLASH_AW = 15;
	localparam int FLASH_WORDS = 8192;
	localparam int PAGE_WORDS = 256;
	// debug access field
	localparam int DBG_LSB = 30;
	localparam logic [1:0] DBG_ENABLED = 2'h2;
	localparam logic [31:0] READ_EN_RESET = 32'h8000ffff;
	localparam logic [31:0] PROG_EN_RESET = 32'h0000ffff;
	localparam logic [11:0] SPECIAL_COMMIT_ADDR = 12'h900;
	// sram and bit-band
	localparam logic [31:0] SRAM_BASE = 32'h20000000;
	localparam logic [31:0] BITBAND_BASE = 32'h22000000;
	localparam int SRAM_AW = 13;
	localparam int BB_BYTE_MULT = 32;
	localparam int BB_BIT_MULT = 4;
	// timing
	localparam int CLK_MHZ = 10;
	localparam int MAX_CLK_MHZ = 50;
	localparam logic [7:0] USEC_RELOAD_RESET = 8'(MAX_CLK_MHZ - 1);
	localparam int PROGRAM_TIME_US = 20;
	localparam int ERASE_TIME_US = 50;
	typedef enum logic [1:0] {FPT_IDLE, FPT_WAIT, FPT_DONE} fpt_state_t;
endpackage

/* File: fpt_us_tick.sv */
// microsecond tick from the reload value
module fpt_us_tick (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reload_in,
	output logic tick_out
);
	logic [7:0] cnt_ff;
	// count down reload..0, one pulse at zero
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_ff <= 8'h00;
			tick_out <= 1'b0;
		end else if (cnt_ff == 8'h00) begin
			cnt_ff <= reload_in;
			tick_out <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff - 8'h01;
			tick_out <= 1'b0;
		end
	end
endmodule // fpt_us_tick

/* File: fpt_sram.sv */
// sram with bit-band alias port; alias write is a single-cycle rmw
module fpt_sram
	import fpt_pkg::*;
(
	input wire logic clk_in,
	input wire logic [31:0] addr_in,
	input wire logic wr_in,
	input wire logic [31:0] wdata_in,
	output logic [31:0] rdata_out
);
	logic [31:0] mem [0:(1 << (SRAM_AW - 2)) - 1];
	logic alias_hit;
	logic [31:0] bb_off;
	logic [SRAM_AW-1:0] byte_idx;
	logic [2:0] bit_idx;
	logic [SRAM_AW-3:0] word_idx;
	logic [31:0] cur_word;
	logic [4:0] lane_bit;
	// decode alias = base + byte*32 + bit*4
	always_comb begin
		alias_hit = (addr_in[31:24] == BITBAND_BASE[31:24]);
		bb_off = addr_in - BITBAND_BASE;
		byte_idx = alias_hit ? SRAM_AW'(bb_off / BB_BYTE_MULT) : addr_in[SRAM_AW-1:0];
		bit_idx = 3'((bb_off % BB_BYTE_MULT) / BB_BIT_MULT);
		word_idx = byte_idx[SRAM_AW-1:2];
		lane_bit = {byte_idx[1:0], bit_idx};
		cur_word = mem[word_idx];
	end
	// alias write touches one bit only, no software rmw needed
	always_ff @(posedge clk_in) begin
		if (wr_in) begin
			if (alias_hit) begin
				mem[word_idx][lane_bit] <= wdata_in[0];
			end else begin
				mem[word_idx] <= wdata_in;
			end
		end
		rdata_out <= alias_hit ? {31'h0, cur_word[lane_bit]} : cur_word;
	end
endmodule // fpt_sram

/* File: fpt_ctrl.sv */
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
module fpt_ctrl
	import fpt_pkg::*;
(
	input wire logic REF_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic POR_IN,
	input wire logic [fpt_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire logic [31:0] CORE_ADDR_IN,
	input wire logic CORE_READ_IN,
	input wire logic CORE_WRITE_IN,
	input wire logic CORE_FETCH_IN,
	input wire logic [31:0] CORE_WDATA_IN,
	output logic [31:0] CORE_RDATA_OUT,
	output logic CORE_RVALID_OUT,
	output logic DEBUG_PORT_EN_OUT,
	output logic JTAG_TAP_EN_OUT,
	output logic FLASH_IRQ_OUT
);
	import fpt_pkg::*;

	////////////////////////////////////////////////////////////////////
	// storage and state
	logic [31:0] flash_mem [0:FLASH_WORDS-1];
	logic [31:0] read_en_ff, prog_en_ff, read_en_commit_ff, prog_en_commit_ff;
	logic [1:0] dbg_live_ff;
	logic [31:0] op_addr_ff, op_data_ff;
	logic [7:0] usec_reload_ff;
	logic [1:0] status_ff, int_mask_ff;
	logic [3:0] ctrl_ff;
	logic [15:0] us_cnt_ff;
	logic [12:0] erase_idx_ff;
	fpt_state_t state_ff;
	logic us_tick;
	logic [31:0] sram_rdata;
	logic sram_sel_ff;
	logic ack_ff;
	logic core_rd_ff;
	logic [31:0] core_flash_data_ff;
	logic core_refused_ff;
	logic bus_wr, bus_rd;
	logic prot_fault, read_fault;
	logic start_write, start_erase, start_commit;
	logic [31:0] wmask;

	// block index and byte-lane mask helpers
	function automatic logic [3:0] block_of(input logic [31:0] a);
		return a[BLOCK_SHIFT+3:BLOCK_SHIFT];
	endfunction
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then ack
	assign bus_wr = AVS_WRITE_IN && !ack_ff;
	assign bus_rd = AVS_READ_IN && !ack_ff;
	assign wmask = lane_mask(AVS_BYTEENABLE_IN);

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			ack_ff <= 1'b0;
			AVS_WAITREQUEST_OUT <= 1'b1;
		end else begin
			ack_ff <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_ff;
			AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN) && !ack_ff);
		end
	end

	// read mux; unmapped reads return zero
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			AVS_READDATA_OUT <= 32'h0;
		end else if (bus_rd) begin
			case (AVS_ADDRESS_IN)
				OFS_OP_ADDR: AVS_READDATA_OUT <= op_addr_ff;
				OFS_OP_DATA: AVS_READDATA_OUT <= op_data_ff;
				OFS_OP_CTRL: AVS_READDATA_OUT <= {28'h0, ctrl_ff};
				OFS_STATUS: AVS_READDATA_OUT <= {29'h0, state_ff != FPT_IDLE, status_ff};
				OFS_INT_MASK: AVS_READDATA_OUT <= {30'h0, int_mask_ff};
				OFS_READ_EN: AVS_READDATA_OUT <= read_en_ff;
				OFS_PROG_EN: AVS_READDATA_OUT <= prog_en_ff;
				OFS_USEC_RELOAD: AVS_READDATA_OUT <= {24'h0, usec_reload_ff};
				default: AVS_READDATA_OUT <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// plain config registers
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			op_addr_ff <= 32'h0;
			op_data_ff <= 32'h0;
			int_mask_ff <= 2'h0;
			usec_reload_ff <= USEC_RELOAD_RESET;
		end else if (bus_wr) begin
			case (AVS_ADDRESS_IN)
				OFS_OP_ADDR: op_addr_ff <= (op_addr_ff & ~wmask) | (AVS_WRITEDATA_IN & wmask);
				OFS_OP_DATA: op_data_ff <= (op_data_ff & ~wmask) | (AVS_WRITEDATA_IN & wmask);
				OFS_INT_MASK: if (AVS_BYTEENABLE_IN[0]) int_mask_ff <= AVS_WRITEDATA_IN[1:0];
				OFS_USEC_RELOAD: if (AVS_BYTEENABLE_IN[0]) usec_reload_ff <= AVS_WRITEDATA_IN[7:0];
				default: ;
			endcase
		end
	end

	// operation starts from a control write while idle
	always_comb begin
		start_write = 1'b0;
		start_erase = 1'b0;
		start_commit = 1'b0;
		if (bus_wr && AVS_ADDRESS_IN == OFS_OP_CTRL && AVS_BYTEENABLE_IN[0]
				&& state_ff == FPT_IDLE) begin
			start_write = AVS_WRITEDATA_IN[CTRL_WRITE_BIT];
			start_erase = AVS_WRITEDATA_IN[CTRL_ERASE_BIT];
			start_commit = AVS_WRITEDATA_IN[CTRL_COMMIT_BIT];
		end
		prot_fault = (start_write || start_erase)
				&& !prog_en_ff[block_of(op_addr_ff)];
	end

	////////////////////////////////////////////////////////////////////
	// protection bits: free until committed; system reset restores committed image, por loads reset values
	always_ff @(posedge REF_CLK_IN) begin
		if (POR_IN) begin
			read_en_ff <= READ_EN_RESET;
			prog_en_ff <= PROG_EN_RESET;
			read_en_commit_ff <= READ_EN_RESET;
			prog_en_commit_ff <= PROG_EN_RESET;
		end else if (SYS_RST_IN) begin
			read_en_ff <= read_en_commit_ff;
			prog_en_ff <= prog_en_commit_ff;
		end else begin
			// ones only where commit allows; committed zeros stay zero
			if (bus_wr && AVS_ADDRESS_IN == OFS_READ_EN)
				read_en_ff <= ((read_en_ff & ~wmask) | (AVS_WRITEDATA_IN & wmask))
						& read_en_commit_ff;
			if (bus_wr && AVS_ADDRESS_IN == OFS_PROG_EN)
				prog_en_ff <= ((prog_en_ff & ~wmask) | (AVS_WRITEDATA_IN & wmask))
						& prog_en_commit_ff;
			if (start_commit) begin
				if (op_addr_ff[11:0] == SPECIAL_COMMIT_ADDR)
					read_en_commit_ff <= read_en_commit_ff & read_en_ff;
				else if (op_addr_ff[0])
					prog_en_commit_ff <= prog_en_commit_ff & prog_en_ff;
				else
					read_en_commit_ff[BLOCKS-1:0] <= read_en_commit_ff[BLOCKS-1:0]
							& read_en_ff[BLOCKS-1:0];
			end
		end
	end

	// debug field is sampled only at power-up, after por has reloaded the reset value, so a committed clear never takes effect
	always_ff @(posedge REF_CLK_IN) begin
		if (POR_IN) begin
			dbg_live_ff <= 2'h0;
		end else if (SYS_RST_IN) begin
			dbg_live_ff <= dbg_live_ff;
		end else if (dbg_live_ff == 2'h0) begin
			dbg_live_ff <= read_en_commit_ff[DBG_LSB+1:DBG_LSB] | 2'h1;
		end
	end

	// debug enable ignores system reset so it only moves at power-up
	always_ff @(posedge REF_CLK_IN) begin
		if (POR_IN) begin
			DEBUG_PORT_EN_OUT <= 1'b0;
		end else if (dbg_live_ff == 2'h0) begin
			DEBUG_PORT_EN_OUT <= (read_en_commit_ff[DBG_LSB+1:DBG_LSB] == DBG_ENABLED);
		end else begin
			DEBUG_PORT_EN_OUT <= (dbg_live_ff == (DBG_ENABLED | 2'h1));
		end
	end

	// test access port stays usable whatever the debug field holds
	always_ff @(posedge REF_CLK_IN) begin
		JTAG_TAP_EN_OUT <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// operation sequencer timed by microsecond ticks
	fpt_us_tick u_tick (
		.clk_in(REF_CLK_IN),
		.rst_in(SYS_RST_IN),
		.reload_in(usec_reload_ff),
		.tick_out(us_tick)
	);

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			state_ff <= FPT_IDLE;
			ctrl_ff <= 4'h0;
			us_cnt_ff <= 16'h0;
			erase_idx_ff <= 13'h0;
		end else begin
			case (state_ff)
				FPT_IDLE: begin
					if ((start_write || start_erase) && !prot_fault) begin
						state_ff <= FPT_WAIT;
						ctrl_ff <= {2'b00, start_erase, start_write};
						us_cnt_ff <= 16'(start_erase ? ERASE_TIME_US : PROGRAM_TIME_US);
					end else if (start_commit) begin
						state_ff <= FPT_WAIT;
						ctrl_ff <= 4'h8;
						us_cnt_ff <= 16'(PROGRAM_TIME_US);
					end
				end
				FPT_WAIT: begin
					if (us_tick) begin
						if (us_cnt_ff == 16'h1) begin
							state_ff <= FPT_DONE;
							erase_idx_ff <= 13'h0;
						end
						us_cnt_ff <= us_cnt_ff - 16'h1;
					end
				end
				FPT_DONE: begin
					// erase walks the page one word a cycle
					if (!ctrl_ff[CTRL_ERASE_BIT] || erase_idx_ff == 13'(PAGE_WORDS - 1)) begin
						state_ff <= FPT_IDLE;
						ctrl_ff <= 4'h0;
					end
					erase_idx_ff <= erase_idx_ff + 13'h1;
				end
				default: state_ff <= FPT_IDLE;
			endcase
		end
	end

	// array updates: program clears bits only, erase sets all ones
	always_ff @(posedge REF_CLK_IN) begin
		if (state_ff == FPT_DONE && ctrl_ff[CTRL_WRITE_BIT])
			flash_mem[op_addr_ff[FLASH_AW-1:2]] <= flash_mem[op_addr_ff[FLASH_AW-1:2]]
					& op_data_ff;
		else if (state_ff == FPT_DONE && ctrl_ff[CTRL_ERASE_BIT])
			flash_mem[{op_addr_ff[FLASH_AW-1:PAGE_SHIFT], erase_idx_ff[7:0]}]
					<= 32'hffffffff;
	end

	////////////////////////////////////////////////////////////////////
	// core access port: fetch always allowed, data gated by read enable
	assign read_fault = CORE_READ_IN && !CORE_FETCH_IN
			&& CORE_ADDR_IN[31:28] == 4'h0
			&& !read_en_ff[block_of(CORE_ADDR_IN)];

	fpt_sram u_sram (
		.clk_in(REF_CLK_IN),
		.addr_in(CORE_ADDR_IN),
		.wr_in(CORE_WRITE_IN && CORE_ADDR_IN[31:28] == SRAM_BASE[31:28]),
		.wdata_in(CORE_WDATA_IN),
		.rdata_out(sram_rdata)
	);

	// refused reads never put array data on the data path
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			core_rd_ff <= 1'b0;
			sram_sel_ff <= 1'b0;
			core_refused_ff <= 1'b0;
			core_flash_data_ff <= 32'h0;
		end else begin
			core_rd_ff <= CORE_READ_IN;
			sram_sel_ff <= CORE_ADDR_IN[31:28] == SRAM_BASE[31:28];
			core_refused_ff <= read_fault;
			core_flash_data_ff <= read_fault ? 32'h0
					: flash_mem[CORE_ADDR_IN[FLASH_AW-1:2]];
		end
	end

	always_comb begin
		CORE_RVALID_OUT = core_rd_ff;
		CORE_RDATA_OUT = sram_sel_ff ? sram_rdata
				: (core_refused_ff ? 32'h0 : core_flash_data_ff);
	end

	// sticky faults, write one to clear; set wins over clear
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			status_ff <= 2'h0;
			FLASH_IRQ_OUT <= 1'b0;
		end else begin
			status_ff <= (status_ff & ~((bus_wr && AVS_ADDRESS_IN == OFS_STATUS
					&& AVS_BYTEENABLE_IN[0]) ? AVS_WRITEDATA_IN[1:0] : 2'h0))
					| {read_fault, prot_fault};
			FLASH_IRQ_OUT <= |(status_ff & int_mask_ff);
		end
	end
endmodule // fpt_ctrl

/* File: fpt_core_model.sv */
// core side bus master: loads, stores and instruction fetches
module fpt_core_model (
	input wire logic clk_in,
	output logic [31:0] addr_out,
	output logic read_out,
	output logic write_out,
	output logic fetch_out,
	output logic [31:0] wdata_out,
	input wire logic [31:0] rdata_in,
	input wire logic rvalid_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial begin
		addr_out = 32'h0;
		wdata_out = 32'h0;
		read_out = 1'b0;
		write_out = 1'b0;
		fetch_out = 1'b0;
	end
	// one-cycle store; released lines show the inverse so stale data never matches
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		write_out <= 1'b1;
		@(posedge clk_in);
		write_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	// one-cycle load or fetch; answer is looked at in the following cycle
	task automatic rd(input logic [31:0] a, input logic f, output logic [31:0] d,
		output logic v);
		@(posedge clk_in);
		addr_out <= a;
		read_out <= !f;
		fetch_out <= f;
		@(posedge clk_in);
		read_out <= 1'b0;
		fetch_out <= 1'b0;
		addr_out <= ~a;
		@(negedge clk_in);
		d = rdata_in;
		v = rvalid_in;
	endtask
endmodule // fpt_core_model

/* File: fpt_ctrl_asserts.sv */
// port-level checker for the protection controller
module fpt_ctrl_asserts (
	input wire logic REF_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic POR_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic AVS_WAITREQUEST_OUT,
	input wire logic [31:0] CORE_ADDR_IN,
	input wire logic CORE_READ_IN,
	input wire logic CORE_WRITE_IN,
	input wire logic [31:0] CORE_WDATA_IN,
	input wire logic [31:0] CORE_RDATA_OUT,
	input wire logic CORE_RVALID_OUT,
	input wire logic DEBUG_PORT_EN_OUT,
	input wire logic JTAG_TAP_EN_OUT
);
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	// store to plain sram, then a load of that word two cycles later
	sequence s_sram_wr;
		CORE_WRITE_IN && CORE_ADDR_IN[31:24] == 8'h20;
	endsequence
	sequence s_same_rd;
		CORE_READ_IN && CORE_ADDR_IN == $past(CORE_ADDR_IN, 2);
	endsequence
	AST_SRAM: assert property (s_sram_wr ##2 s_same_rd |=> CORE_RDATA_OUT == $past(CORE_WDATA_IN, 3))
		else $error("sram word did not read back");
	AST_WAIT: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
		else $error("no answer one cycle after request");
	AST_WAIT_ONE: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
		else $error("waitrequest low longer than one cycle");
	AST_RST_WAIT: assert property (disable iff (1'b0) SYS_RST_IN |=> AVS_WAITREQUEST_OUT)
		else $error("waitrequest low in reset");
	AST_RVALID: assert property (CORE_READ_IN |=> CORE_RVALID_OUT)
		else $error("load not answered next cycle");
	AST_RV_CAUSE: assert property (CORE_RVALID_OUT |-> $past(CORE_READ_IN))
		else $error("load answer without load");
	AST_JTAG: assert property (JTAG_TAP_EN_OUT)
		else $error("test access port disabled");
	AST_DBG: assert property (!POR_IN && !$past(POR_IN) && !$past(POR_IN, 2) |-> $stable(DEBUG_PORT_EN_OUT))
		else $error("debug enable moved outside power-up");
endmodule // fpt_ctrl_asserts
bind fpt_ctrl fpt_ctrl_asserts u_chk (.REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
	.POR_IN(POR_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
	.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .CORE_ADDR_IN(CORE_ADDR_IN),
	.CORE_READ_IN(CORE_READ_IN), .CORE_WRITE_IN(CORE_WRITE_IN), .CORE_WDATA_IN(CORE_WDATA_IN),
	.CORE_RDATA_OUT(CORE_RDATA_OUT), .CORE_RVALID_OUT(CORE_RVALID_OUT),
	.DEBUG_PORT_EN_OUT(DEBUG_PORT_EN_OUT), .JTAG_TAP_EN_OUT(JTAG_TAP_EN_OUT));

/* File: test_flash_protection_timing.sv */
module test_flash_protection_timing;
	timeunit 1ns;
	timeprecision 1ns;
	import fpt_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic por = 1'b1;
	logic [7:0] av_a = 8'h0;
	logic av_r = 1'b0;
	logic av_w = 1'b0;
	logic [31:0] av_d = 32'h0;
	logic [31:0] av_q, c_a, c_wd, c_q, a, b, d, e, q;
	logic c_r, c_w, c_f, c_v, wreq, dbg, tap, irq, v;
	logic [31:0] lfsr = 32'h8b39;
	logic [31:0] c_q_s;
	int n_fail = 0;
	int samples_checked = 0;
	fpt_ctrl DUT (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .POR_IN(por), .AVS_ADDRESS_IN(av_a),
		.AVS_READ_IN(av_r), .AVS_WRITE_IN(av_w), .AVS_BYTEENABLE_IN(4'hf),
		.AVS_WRITEDATA_IN(av_d), .AVS_READDATA_OUT(av_q), .AVS_WAITREQUEST_OUT(wreq),
		.CORE_ADDR_IN(c_a), .CORE_READ_IN(c_r), .CORE_WRITE_IN(c_w), .CORE_FETCH_IN(c_f),
		.CORE_WDATA_IN(c_wd), .CORE_RDATA_OUT(c_q), .CORE_RVALID_OUT(c_v),
		.DEBUG_PORT_EN_OUT(dbg), .JTAG_TAP_EN_OUT(tap), .FLASH_IRQ_OUT(irq));
	fpt_core_model core (.clk_in(clk), .addr_out(c_a), .read_out(c_r), .write_out(c_w),
		.fetch_out(c_f), .wdata_out(c_wd), .rdata_in(c_q), .rvalid_in(c_v));
	// 10 MHz clock
	initial forever #50 clk = ~clk;
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task rnd(output logic [31:0] r);
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		r = lfsr;
	endtask
	// alias word of one sram bit
	function automatic logic [31:0] bb(input logic [31:0] off, input int n);
		return BITBAND_BASE + off * BB_BYTE_MULT + n * BB_BIT_MULT;
	endfunction
	// one avalon cycle, held until waitrequest is seen low
	task av(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rq);
		int i;
		@(posedge clk);
		av_a <= ad;
		av_d <= wd;
		av_w <= wr;
		av_r <= !wr;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (wreq !== 1'b0 && i < 50);
		rq = av_q;
		av_w <= 1'b0;
		av_r <= 1'b0;
		if (i >= 50) begin
			chk(0, 1, "bus hang");
			end_of_test;
		end
	endtask
	task w(input logic [7:0] ad, input logic [31:0] wd);
		av(1'b1, ad, wd, q);
	endtask
	task rc(input logic [7:0] ad, input logic [31:0] exp, input string m);
		av(1'b0, ad, 32'h0, q);
		chk(q, exp, m);
	endtask
	// flash operation, then poll busy with a bound
	task op(input logic [31:0] ad, input logic [31:0] wd, input int bitn);
		int i;
		w(OFS_OP_DATA, wd);
		w(OFS_OP_ADDR, ad);
		w(OFS_OP_CTRL, 32'h1 << bitn);
		i = 0;
		do begin
			av(1'b0, OFS_STATUS, 32'h0, q);
			i++;
		end while (q[STAT_BUSY_BIT] !== 1'b0 && i < 1000);
		if (i >= 1000) begin
			chk(0, 1, "op hang");
			end_of_test;
		end
	endtask
	task cr(input logic [31:0] ad, input logic f, input logic [31:0] exp, input string m);
		core.rd(ad, f, c_q_s, v);
		chk(c_q_s, exp, m);
		if (!f)
			chk({31'h0, v}, 32'h1, m);
	endtask
	// power-up and system reset pulse
	task pulse(input logic p);
		@(posedge clk);
		rst <= 1'b1;
		por <= p;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// watchdog on the whole run
	initial begin
		repeat (100000) @(posedge clk);
		chk(0, 1, "run timeout");
		end_of_test;
	end
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		repeat (2) @(posedge clk);
		rc(OFS_READ_EN, {DBG_ENABLED, 14'h0, 16'hffff}, "read enable reset");
		rc(OFS_PROG_EN, 32'h0000ffff, "program enable reset");
		rc(OFS_USEC_RELOAD, 32'(MAX_CLK_MHZ - 1), "reload reset");
		rc(8'h20, 32'h0, "unmapped");
		chk({30'h0, dbg, tap}, 32'h3, "debug and tap on");
		w(OFS_USEC_RELOAD, 32'(CLK_MHZ - 1));
		rc(OFS_USEC_RELOAD, 32'(CLK_MHZ - 1), "reload");
		$display("test registers done");
		for (int k = 0; k < 4; k++) begin
			rnd(d);
			rnd(e);
			a = SRAM_BASE | {19'h0, d[12:2], 2'b0};
			core.wr(a, d);
			cr(a, 1'b0, d, "sram word");
			cr(bb(a[12:0] + e[1:0], e[4:2]), 1'b0, {31'h0, d[8 * e[1:0] + e[4:2]]}, "alias rd");
			core.wr(bb(a[12:0] + e[1:0], e[4:2]), {31'h0, ~d[8 * e[1:0] + e[4:2]]});
			cr(a, 1'b0, d ^ (32'h1 << (8 * e[1:0] + e[4:2])), "alias wr");
		end
		$display("test sram done");
		rnd(d);
		rnd(e);
		a = {17'h0, 4'h1, d[10:2], 2'b0};
		b = a ^ 32'h400;
		op(a, 0, CTRL_ERASE_BIT);
		op(b, 0, CTRL_ERASE_BIT);
		op(a, d, CTRL_WRITE_BIT);
		cr(a, 1'b0, d, "program");
		op(a, e, CTRL_WRITE_BIT);
		cr(a, 1'b0, d & e, "program only clears");
		op(b, d, CTRL_WRITE_BIT);
		op(a, 0, CTRL_ERASE_BIT);
		cr(a, 1'b0, 32'hffffffff, "erase ones");
		cr(b, 1'b0, d, "other page kept");
		$display("test flash done");
		a = {17'h0, 4'h3, e[10:2], 2'b0};
		op(a, 0, CTRL_ERASE_BIT);
		w(OFS_PROG_EN, 32'h0000fff7);
		w(OFS_INT_MASK, 32'h1);
		op(a, d, CTRL_WRITE_BIT);
		cr(a, 1'b0, 32'hffffffff, "protected kept");
		rc(OFS_STATUS, 32'h1, "program fault");
		chk({31'h0, irq}, 32'h1, "fault irq");
		w(OFS_STATUS, 32'h1);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		$display("test program protect done");
		a = {17'h0, 4'h5, d[10:2], 2'b0};
		op(a, 0, CTRL_ERASE_BIT);
		op(a, d, CTRL_WRITE_BIT);
		w(OFS_READ_EN, 32'h8000ffdf);
		cr(a, 1'b0, 32'h0, "read protect zero");
		rc(OFS_STATUS, 32'h2, "read fault");
		cr(a, 1'b1, d, "fetch allowed");
		op(a, e, CTRL_WRITE_BIT);
		cr(a, 1'b1, d & e, "write allowed");
		w(OFS_STATUS, 32'h2);
		$display("test read protect done");
		pulse(1'b1);
		rc(OFS_PROG_EN, 32'h0000ffff, "por restores");
		rc(OFS_READ_EN, 32'h8000ffff, "por restores");
		w(OFS_PROG_EN, 32'h0000fffe);
		op(32'h1, 0, CTRL_COMMIT_BIT);
		w(OFS_READ_EN, 32'h8000fffd);
		op(32'h0, 0, CTRL_COMMIT_BIT);
		w(OFS_PROG_EN, 32'h0000ffff);
		pulse(1'b0);
		rc(OFS_PROG_EN, 32'h0000fffe, "committed kept");
		rc(OFS_READ_EN, 32'h8000fffd, "committed kept");
		$display("test commit done");
		w(OFS_READ_EN, 32'h0000fff9);
		op({20'h0, SPECIAL_COMMIT_ADDR}, 0, CTRL_COMMIT_BIT);
		pulse(1'b0);
		chk({31'h0, dbg}, 32'h1, "debug until power-up");
		rc(OFS_READ_EN, 32'h0000fff9, "debug field committed");
		$display("test debug done");
		end_of_test;
	end
endmodule // test_flash_protection_timing
